// file: include/iwdt_pkg.sv
package iwdt_pkg;
   localparam logic [11:0] DISABLE_PORT_ADDR = 12'h0043;
   localparam logic [11:0] PERIOD_PORT_ADDR = 12'h0443;
   localparam logic [11:0] DISABLE_ALIAS_ADDR = 12'h0843;
   localparam logic [7:0] PERIOD_RESET = 8'h00;
   localparam logic [7:0] READ_DATA_IDLE = 8'h00;
   localparam int CLK_HZ = 32'h02FA_F080;
   localparam int TICK_SEC = 1;
   localparam int TICK_CYCLES = CLK_HZ * TICK_SEC;
   localparam logic [25:0] TICK_RESET = 26'h000_0000;
   localparam logic [7:0] COUNT_RESET = 8'h00;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } iwdt_io_s;

   typedef enum logic [1:0] {
      IWDT_IDLE = 2'b01,
      IWDT_RUN = 2'b10
   } iwdt_state_e;
endpackage : iwdt_pkg

// file: src/iwdt_core.sv
`timescale 1ns/1ps
// How it works
// - a write to the period port loads the period and starts nothing.
// - a read of the period port starts an idle countdown or refreshes it.
// - a read of either disable port stops the countdown with no reset.
// - the period counts whole seconds, one per count, 1 to 255; a period of 0 also gives 1 second.
// - expiry of a running countdown raises the board reset request.
module iwdt_core #(
   parameter int TICK_CYCLES = iwdt_pkg::TICK_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire iwdt_pkg::iwdt_io_s io_i,
   output logic [7:0] rdata_o,
   output logic running_o,
   output logic reset_req_o
);
   iwdt_pkg::iwdt_state_e state_reg;
   logic [7:0] period_reg;
   logic [7:0] count_reg;
   logic [25:0] tick_reg;
   logic tick;
   logic kick;
   logic stop;
   logic expire;
   logic req_reg;

   function automatic logic is_disable(input logic [11:0] a);
      is_disable = (a == iwdt_pkg::DISABLE_PORT_ADDR) ||
                   (a == iwdt_pkg::DISABLE_ALIAS_ADDR);
   endfunction : is_disable

   function automatic logic is_period(input logic [11:0] a);
      is_period = (a == iwdt_pkg::PERIOD_PORT_ADDR);
   endfunction : is_period

   assign kick = io_i.rd && is_period(io_i.addr);
   assign stop = io_i.rd && is_disable(io_i.addr);
   assign tick = (tick_reg == 26'(TICK_CYCLES - 1));
   assign expire = (state_reg == iwdt_pkg::IWDT_RUN) && tick &&
                   (count_reg <= 8'h01) && !kick && !stop;

   // period byte; writes never touch the countdown
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         period_reg <= iwdt_pkg::PERIOD_RESET;
      end else if (io_i.wr && is_period(io_i.addr)) begin
         period_reg <= io_i.wdata;
      end
   end

   // one-second prescaler; a kick restarts it so a refresh gives full seconds
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_reg <= iwdt_pkg::TICK_RESET;
      end else if (kick || tick) begin
         tick_reg <= iwdt_pkg::TICK_RESET;
      end else begin
         tick_reg <= tick_reg + 26'h000_0001;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= iwdt_pkg::IWDT_IDLE;
         count_reg <= iwdt_pkg::COUNT_RESET;
      end else begin
         case (state_reg)
            iwdt_pkg::IWDT_IDLE: begin
               if (kick && !stop) begin
                  state_reg <= iwdt_pkg::IWDT_RUN;
                  count_reg <= period_reg;
               end
            end
            iwdt_pkg::IWDT_RUN: begin
               if (stop) begin
                  state_reg <= iwdt_pkg::IWDT_IDLE;
               end else if (kick) begin
                  count_reg <= period_reg;
               end else if (expire) begin
                  state_reg <= iwdt_pkg::IWDT_IDLE;
               end else if (tick) begin
                  count_reg <= count_reg - 8'h01;
               end
            end
            default: begin
               state_reg <= iwdt_pkg::IWDT_IDLE;
            end
         endcase
      end
   end

   // one-cycle reset request pulse, registered
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         req_reg <= 1'b0;
      end else begin
         req_reg <= expire;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= iwdt_pkg::READ_DATA_IDLE;
      end else if (kick) begin
         rdata_o <= period_reg;
      end else begin
         rdata_o <= iwdt_pkg::READ_DATA_IDLE;
      end
   end

   assign running_o = (state_reg == iwdt_pkg::IWDT_RUN);
   assign reset_req_o = req_reg;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   property p_write_no_start;
      (state_reg == iwdt_pkg::IWDT_IDLE) && io_i.wr && !io_i.rd |=>
         state_reg == iwdt_pkg::IWDT_IDLE;
   endproperty
   a_write_no_start: assert property (p_write_no_start)
      else $error("period write started countdown");

   property p_write_loads;
      io_i.wr && io_i.addr == iwdt_pkg::PERIOD_PORT_ADDR |=>
         period_reg == $past(io_i.wdata);
   endproperty
   a_write_loads: assert property (p_write_loads)
      else $error("period not loaded");

   property p_kick_runs;
      kick && !stop |=> running_o;
   endproperty
   a_kick_runs: assert property (p_kick_runs)
      else $error("enable read did not run");

   sequence s_quiet;
      !running_o ##1 !reset_req_o;
   endsequence

   property p_stop_idle;
      stop |=> s_quiet;
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("disable read did not stop");

   property p_reload;
      running_o && kick && !stop |=> count_reg == $past(period_reg);
   endproperty
   a_reload: assert property (p_reload)
      else $error("refresh did not reload period");

   property p_expire_req;
      expire |=> reset_req_o && !running_o;
   endproperty
   a_expire_req: assert property (p_expire_req)
      else $error("expiry without reset request");

   property p_req_cause;
      reset_req_o |-> $past(running_o) && $past(tick);
   endproperty
   a_req_cause: assert property (p_req_cause)
      else $error("reset request without expiry");

   property p_count_step;
      running_o && tick && !kick && !stop && count_reg > 8'h01 |=>
         count_reg == $past(count_reg) - 8'h01;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("count did not step once per second");

   property p_tick_spacing;
      tick |=> !tick;
   endproperty
   a_tick_spacing: assert property (p_tick_spacing)
      else $error("tick too frequent");

   // a refresh must also hold off any request in the same cycle
   property p_kick_no_req;
      kick |=> !reset_req_o;
   endproperty
   a_kick_no_req: assert property (p_kick_no_req)
      else $error("refresh did not hold off reset request");

   sequence s_one_pulse;
      reset_req_o ##1 !reset_req_o;
   endsequence

   property p_req_pulse;
      expire |=> s_one_pulse;
   endproperty
   a_req_pulse: assert property (p_req_pulse)
      else $error("reset request not a single pulse");

   property p_rdata_read;
      kick |=> rdata_o == $past(period_reg);
   endproperty
   a_rdata_read: assert property (p_rdata_read)
      else $error("period read back wrong");

   property p_rdata_quiet;
      !kick |=> rdata_o == iwdt_pkg::READ_DATA_IDLE;
   endproperty
   a_rdata_quiet: assert property (p_rdata_quiet)
      else $error("read data not idle");

   property p_idle_hold;
      !running_o && !kick |=> !running_o;
   endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("countdown started without enable read");

   // a new period waits for the next refresh before it takes effect
   property p_write_keeps_count;
      running_o && io_i.wr && !kick && !stop && !tick |=>
         count_reg == $past(count_reg);
   endproperty
   a_write_keeps_count: assert property (p_write_keeps_count)
      else $error("period write disturbed running count");
endmodule : iwdt_core

// file: dv/iwdt_host_model.sv
`timescale 1ns/1ps
module iwdt_host_model (
   input wire logic ref_clk_i,
   output iwdt_pkg::iwdt_io_s io_o
);
   initial io_o = '0;
   // one io cycle, strobe held across a single rising edge
   task automatic cyc(input logic [11:0] a, input logic [7:0] d,
         input logic w);
      @(negedge ref_clk_i);
      io_o <= '{a, d, w, !w};
      @(negedge ref_clk_i);
      io_o <= '{a, ~d, 1'b0, 1'b0};
   endtask : cyc
endmodule : iwdt_host_model

// file: dv/test_io_port_watchdog_timer.sv
`timescale 1ns/1ps
module test_io_port_watchdog_timer;
   localparam int T = 10;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   iwdt_pkg::iwdt_io_s io;
   logic [7:0] rdata;
   logic running;
   logic reset_req;
   int errors = 0, check_count = 0, cyc = 0, seed = 99, n, exp_cyc;
   int note_q[$];
   iwdt_core #(.TICK_CYCLES(T)) u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .io_i(io), .rdata_o(rdata), .running_o(running),
      .reset_req_o(reset_req));
   iwdt_host_model u_host (.ref_clk_i(ref_clk_i), .io_o(io));
   initial forever #10 ref_clk_i = ~ref_clk_i;
   task automatic chk(input string nm, input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s exp %0h got %0h", nm, e, s);
      end
   endtask : chk
   task automatic end_of_test;
      if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc > 2000) begin
         errors++;
         end_of_test();
      end
   end
   // each reset pulse takes the oldest expected cycle off the queue
   always @(negedge ref_clk_i) begin
      if (reset_req === 1'b1) begin
         exp_cyc = note_q.size() ? note_q.pop_front() : -1;
         chk("pulse_cycle", cyc, exp_cyc);
      end
   end
   initial begin
      repeat (6) @(negedge ref_clk_i);
      rst_i = 1'b0;
      chk("idle_run", running, 1'b0);
      n = ($random(seed) & 8'hff) | 1;
      u_host.cyc(12'h0443, n[7:0], 1'b1);
      chk("no_start", running, 1'b0);
      u_host.cyc(12'h0443, 8'h00, 1'b0);
      chk("rdata", rdata, n);
      chk("start", running, 1'b1);
      u_host.cyc(12'h0843, 8'h00, 1'b1);
      chk("wr_stop_port", running, 1'b1);
      u_host.cyc(12'h0444, 8'h00, 1'b0);
      chk("rdata_unmapped", rdata, 8'h00);
      for (int j = 0; j < 2; j++) begin
         u_host.cyc(12'h0443, 8'h00, 1'b0);
         u_host.cyc(j ? 12'h0843 : 12'h0043, 8'h00, 1'b0);
         chk("stopped", running, 1'b0);
      end
      for (int i = 1; i <= 3; i++) begin
         u_host.cyc(12'h0443, i[7:0], 1'b1);
         u_host.cyc(12'h0443, 8'h00, 1'b0);
         repeat (i * T - 5) @(negedge ref_clk_i);
         u_host.cyc(12'h0443, 8'h00, 1'b0);
         note_q.push_back(cyc + i * T);
         repeat (i * T + 2) @(negedge ref_clk_i);
         chk("expired", running, 1'b0);
      end
      u_host.cyc(12'h0443, 8'h00, 1'b0);
      chk("rerun", running, 1'b1);
      rst_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      rst_i = 1'b0;
      chk("reset_idle", running, 1'b0);
      u_host.cyc(12'h0443, 8'h00, 1'b0);
      u_host.cyc(12'h0043, 8'h00, 1'b0);
      repeat (4 * T) @(negedge ref_clk_i);
      chk("notes_left", note_q.size(), 0);
      end_of_test();
   end
endmodule : test_io_port_watchdog_timer
